// file: hw/vcsa_alu.sv
`timescale 1ns/1ps
module vcsa_alu (
  input  wire logic [2:0]  op,
  input  wire logic [31:0] src0,
  input  wire logic [31:0] src1,
  input  wire logic [31:0] acc_lo,
  input  wire logic [31:0] result_old,
  output logic      [31:0] result,
  output logic      [31:0] acc_next,
  output logic             dec_y,
  output logic             dec_z,
  output logic             zero_any,
  output logic             sat_any,
  output logic             op_valid
);

  logic [15:0] cs_max [2];
  logic        cs_dec [2];
  logic [15:0] ab_val [2];
  logic        ab_sat [2];
  logic        ab_zero [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_half
      wire [31:0] src  = (g == 0) ? src0 : src1;
      wire [15:0] diff = src[31:16] - src[15:0];
      wire [15:0] ax   = src0[16*g +: 16];
      assign cs_dec[g] = !diff[15] && (diff != 16'h0000);
      assign cs_max[g] = cs_dec[g] ? src[31:16] : src[15:0];
      assign ab_sat[g]  = (ax == vcsa_pkg::HALF_MIN);
      assign ab_val[g]  = ab_sat[g] ? vcsa_pkg::HALF_MAX :
                          ax[15] ? 16'h0000 - ax : ax;
      assign ab_zero[g] = (ab_val[g] == 16'h0000);
    end
  endgenerate

  assign dec_y    = cs_dec[0];
  assign dec_z    = cs_dec[1];
  assign zero_any = ab_zero[0] | ab_zero[1];
  assign sat_any  = ab_sat[0] | ab_sat[1];

  always_comb begin
    result   = result_old;
    acc_next = acc_lo;
    op_valid = 1'b1;
    unique case (op)
      vcsa_pkg::VCSA_OP_DUAL_LEFT: begin
        result   = {cs_max[0], cs_max[1]};
        acc_next = {acc_lo[29:0], dec_z, dec_y};
      end
      vcsa_pkg::VCSA_OP_DUAL_RIGHT: begin
        result   = {cs_max[0], cs_max[1]};
        acc_next = {dec_y, dec_z, acc_lo[31:2]};
      end
      vcsa_pkg::VCSA_OP_ONE_LEFT: begin
        result   = {result_old[31:16], cs_max[0]};
        acc_next = {acc_lo[30:0], dec_y};
      end
      vcsa_pkg::VCSA_OP_ONE_RIGHT: begin
        result   = {result_old[31:16], cs_max[0]};
        acc_next = {dec_y, acc_lo[31:1]};
      end
      vcsa_pkg::VCSA_OP_ABS: begin
        result = {ab_val[1], ab_val[0]};
      end
      default: begin
        op_valid = 1'b0;
      end
    endcase
  end

endmodule // vcsa_alu

// file: hw/vcsa_top.sv
`timescale 1ns/1ps
// Operation
// - dual: src0 max high, src1 max low
// - dual four operands, single one register
// - dual left: shift two, src1 bit1
// - dual right: shift two, src0 bit31
// - second source decision bit shifted first
// - single left: shift one, lsb decision
// - single right: shift one, bit31 decision
// - maximum by wrapped 16-bit difference sign
// - absolute value of both halves
// - non-negative passes, negative is negated
// - most negative half saturates to max
// - zero flag when any half zero
// - abs clears negative, rewrites zero and overflow
// - overflow flag when any half saturated
// - sticky overflow set with overflow
module vcsa_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  logic [1:0]  rst_sync_reg;
  wire         rst_ok = rst_sync_reg[1];

  logic [31:0] src0_reg;
  logic [31:0] src1_reg;
  logic [2:0]  cmd_reg;
  logic [31:0] result_reg;
  logic [31:0] acc_lo_reg;
  logic [7:0]  acc_ext_reg;
  logic [3:0]  flags_reg;
  logic [2:0]  irq_st_reg;
  logic [2:0]  irq_msk_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic        irq_reg;

  logic [31:0] alu_result;
  logic [31:0] alu_acc;
  logic        alu_dec_y;
  logic        alu_dec_z;
  logic        alu_zero;
  logic        alu_sat;
  logic        alu_valid;

  // reset released through two flops; assertion is still asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // bus decode: a request is answered one cycle after it appears and
  // taken on the following edge, so every access costs two cycles
  wire take    = (avs_read | avs_write) & ~wait_reg;
  wire wr_take = avs_write & ~wait_reg;
  wire rd_take = avs_read & ~wait_reg;
  wire hit_src0 = (avs_address == vcsa_pkg::OFS_SRC0);
  wire hit_src1 = (avs_address == vcsa_pkg::OFS_SRC1);
  wire hit_cmd  = (avs_address == vcsa_pkg::OFS_CMD);
  wire hit_res  = (avs_address == vcsa_pkg::OFS_RESULT);
  wire hit_acc  = (avs_address == vcsa_pkg::OFS_ACC_LO);
  wire hit_ext  = (avs_address == vcsa_pkg::OFS_ACC_EXT);
  wire hit_flg  = (avs_address == vcsa_pkg::OFS_FLAGS);
  wire hit_ist  = (avs_address == vcsa_pkg::OFS_IRQ_ST);
  wire hit_msk  = (avs_address == vcsa_pkg::OFS_IRQ_MSK);

  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  wire [31:0] wd_src0 = merge(src0_reg, avs_writedata, be_mask);
  wire [31:0] wd_src1 = merge(src1_reg, avs_writedata, be_mask);
  wire [31:0] wd_acc  = merge(acc_lo_reg, avs_writedata, be_mask);

  // command write launches the operation; it needs byte lane 0
  wire cmd_wr   = wr_take & hit_cmd & avs_byteenable[0];
  wire op_fire  = cmd_wr & alu_valid;
  wire bad_cmd  = cmd_wr & ~alu_valid;
  wire is_abs   = (avs_writedata[2:0] == vcsa_pkg::VCSA_OP_ABS);
  wire abs_fire = op_fire & is_abs;
  wire cs_fire  = op_fire & ~is_abs;

  vcsa_alu u_alu (
    .op         (avs_writedata[2:0]),
    .src0       (src0_reg),
    .src1       (src1_reg),
    .acc_lo     (acc_lo_reg),
    .result_old (result_reg),
    .result     (alu_result),
    .acc_next   (alu_acc),
    .dec_y      (alu_dec_y),
    .dec_z      (alu_dec_z),
    .zero_any   (alu_zero),
    .sat_any    (alu_sat),
    .op_valid   (alu_valid)
  );

  wire [3:0] flags_abs = {flags_reg[vcsa_pkg::FLG_STICKY] | alu_sat,
                          alu_sat, 1'b0, alu_zero};
  wire [3:0] flags_sw  = avs_byteenable[0] ? avs_writedata[3:0] : flags_reg;
  wire [3:0] flags_next = abs_fire ? flags_abs :
                          (wr_take & hit_flg) ? flags_sw : flags_reg;

  // compare-select never touches flags or extension
  wire [7:0] ext_next = (wr_take & hit_ext & avs_byteenable[0]) ?
                        avs_writedata[7:0] : acc_ext_reg;
  wire [31:0] acc_next = cs_fire ? alu_acc :
                         (wr_take & hit_acc) ? wd_acc : acc_lo_reg;

  // events; a set in the same cycle as the read-clear wins
  wire [2:0] irq_ev  = {bad_cmd, abs_fire & alu_sat, op_fire};
  wire [2:0] irq_clr = (rd_take & hit_ist) ? 3'h7 : 3'h0;
  wire [2:0] irq_st_next = (irq_st_reg & ~irq_clr) | irq_ev;
  wire [2:0] msk_next = (wr_take & hit_msk & avs_byteenable[0]) ?
                        avs_writedata[2:0] : irq_msk_reg;

  wire [31:0] rd_mux =
    hit_src0 ? src0_reg :
    hit_src1 ? src1_reg :
    hit_cmd  ? {29'h0, cmd_reg} :
    hit_res  ? result_reg :
    hit_acc  ? acc_lo_reg :
    hit_ext  ? {24'h0, acc_ext_reg} :
    hit_flg  ? {28'h0, flags_reg} :
    hit_ist  ? {29'h0, irq_st_reg} :
    hit_msk  ? {29'h0, irq_msk_reg} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      wait_reg  <= 1'b1;
      rdata_reg <= vcsa_pkg::WORD_RST;
    end else begin
      wait_reg <= ~((avs_read | avs_write) & wait_reg);
      if (avs_read & wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      src0_reg <= vcsa_pkg::WORD_RST;
      src1_reg <= vcsa_pkg::WORD_RST;
    end else begin
      if (wr_take & hit_src0) begin
        src0_reg <= wd_src0;
      end
      if (wr_take & hit_src1) begin
        src1_reg <= wd_src1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      cmd_reg    <= 3'h0;
      result_reg <= vcsa_pkg::WORD_RST;
    end else if (op_fire) begin
      cmd_reg    <= avs_writedata[2:0];
      result_reg <= alu_result;
    end
  end

  // extension is only ever written by software, never by ops
  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      acc_lo_reg  <= vcsa_pkg::WORD_RST;
      acc_ext_reg <= vcsa_pkg::EXT_RST;
      flags_reg   <= vcsa_pkg::FLAGS_RST;
    end else begin
      acc_lo_reg  <= acc_next;
      acc_ext_reg <= ext_next;
      flags_reg   <= flags_next;
    end
  end

  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      irq_st_reg  <= vcsa_pkg::IRQ_RST;
      irq_msk_reg <= vcsa_pkg::IRQ_RST;
      irq_reg     <= 1'b0;
    end else begin
      irq_st_reg  <= irq_st_next;
      irq_msk_reg <= msk_next;
      irq_reg     <= |(irq_st_next & msk_next);
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;
  assign irq             = irq_reg;

  // check helpers, independent of the datapath
  wire [15:0] chk_ydiff = src0_reg[31:16] - src0_reg[15:0];
  wire [15:0] chk_zdiff = src1_reg[31:16] - src1_reg[15:0];
  wire        chk_y_up  = ~chk_ydiff[15] & (chk_ydiff != 16'h0000);
  wire        chk_z_up  = ~chk_zdiff[15] & (chk_zdiff != 16'h0000);
  wire [2:0]  fire_op   = avs_writedata[2:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_ok);

  a_dual_placement: assert property (
    (cs_fire && !fire_op[1]) |=>
      result_reg[31:16] == (($past(chk_y_up)) ? $past(src0_reg[31:16])
                                              : $past(src0_reg[15:0])) &&
      result_reg[15:0]  == (($past(chk_z_up)) ? $past(src1_reg[31:16])
                                              : $past(src1_reg[15:0])))
    else $error("dual compare-select result halves wrong");

  a_single_upper: assert property (
    (cs_fire && fire_op[1]) |=>
      result_reg[31:16] == $past(result_reg[31:16]) &&
      result_reg[15:0] == ($past(chk_y_up) ? $past(src0_reg[31:16])
                                           : $past(src0_reg[15:0])))
    else $error("single compare-select result wrong");

  a_dual_left: assert property (
    (op_fire && fire_op == vcsa_pkg::VCSA_OP_DUAL_LEFT) |=>
      acc_lo_reg == {$past(acc_lo_reg[29:0]), $past(chk_z_up),
                     $past(chk_y_up)})
    else $error("dual left history bits wrong");

  a_dual_right: assert property (
    (op_fire && fire_op == vcsa_pkg::VCSA_OP_DUAL_RIGHT) |=>
      acc_lo_reg[31] == $past(chk_y_up) &&
      acc_lo_reg[30] == $past(chk_z_up) &&
      acc_lo_reg[29:0] == $past(acc_lo_reg[31:2]))
    else $error("dual right history bits wrong");

  a_one_left: assert property (
    (op_fire && fire_op == vcsa_pkg::VCSA_OP_ONE_LEFT) |=>
      acc_lo_reg == {$past(acc_lo_reg[30:0]), $past(chk_y_up)})
    else $error("single left history bit wrong");

  a_one_right: assert property (
    (op_fire && fire_op == vcsa_pkg::VCSA_OP_ONE_RIGHT) |=>
      acc_lo_reg == {$past(chk_y_up), $past(acc_lo_reg[31:1])})
    else $error("single right history bit wrong");

  a_abs_saturate: assert property (
    (abs_fire && src0_reg[15:0] == vcsa_pkg::HALF_MIN) |=>
      result_reg[15:0] == vcsa_pkg::HALF_MAX &&
      flags_reg[vcsa_pkg::FLG_OVF] && flags_reg[vcsa_pkg::FLG_STICKY])
    else $error("abs did not saturate most negative half");

  a_abs_zero_neg: assert property (
    abs_fire |=>
      flags_reg[vcsa_pkg::FLG_ZERO] ==
        (result_reg[31:16] == 16'h0000 || result_reg[15:0] == 16'h0000) &&
      !flags_reg[vcsa_pkg::FLG_NEG] &&
      !result_reg[31] && !result_reg[15])
    else $error("abs zero or negative flag wrong");

  a_abs_sticky: assert property (
    abs_fire |=>
      flags_reg[vcsa_pkg::FLG_STICKY] ==
        ($past(flags_reg[vcsa_pkg::FLG_STICKY]) |
         flags_reg[vcsa_pkg::FLG_OVF]))
    else $error("sticky overflow flag wrong");

  a_cs_keeps_flags: assert property (
    cs_fire |=> $stable(flags_reg) && $stable(acc_ext_reg))
    else $error("compare-select changed flags or extension");

  a_wait_one_cycle: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  a_irq_follows: assert property (
    irq == |($past(irq_st_next) & $past(msk_next)))
    else $error("interrupt output does not follow status and mask");

endmodule // vcsa_top

// file: inc/vcsa_pkg.sv
package vcsa_pkg;

  localparam int DATA_W  = 32;
  localparam int HALF_W  = 16;
  localparam int EXT_W   = 8;
  localparam int ADDR_W  = 8;
  localparam int FLAGS_W = 4;
  localparam int IRQ_W   = 3;
  localparam int SYNC_W  = 2;

  // byte offsets of the register map
  localparam logic [ADDR_W-1:0] OFS_SRC0    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SRC1    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RESULT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ACC_LO  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ACC_EXT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 8'h20;

  // arithmetic flag positions
  localparam int FLG_ZERO   = 0;
  localparam int FLG_NEG    = 1;
  localparam int FLG_OVF    = 2;
  localparam int FLG_STICKY = 3;

  // interrupt status positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_SAT  = 1;
  localparam int IRQ_BAD  = 2;

  // reset values
  localparam logic [DATA_W-1:0]  WORD_RST  = 32'h0000_0000;
  localparam logic [EXT_W-1:0]   EXT_RST   = 8'h00;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 4'h0;
  localparam logic [IRQ_W-1:0]   IRQ_RST   = 3'h0;

  localparam logic [HALF_W-1:0] HALF_MAX = 16'h7FFF;
  localparam logic [HALF_W-1:0] HALF_MIN = 16'h8000;

  typedef enum logic [2:0] {
    VCSA_OP_DUAL_LEFT  = 3'h0,
    VCSA_OP_DUAL_RIGHT = 3'h1,
    VCSA_OP_ONE_LEFT   = 3'h2,
    VCSA_OP_ONE_RIGHT  = 3'h3,
    VCSA_OP_ABS        = 3'h4
  } vcsa_op_t;

endpackage

// file: tb/vcsa_host_model.sv
`timescale 1ns/1ps
module vcsa_host_model (
  input  wire logic        clk,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // idle cycles before each request, so the host can be slow or prompt
  int gap  = 0;
  int hung = 0;

  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // released address, data and enables show the inverse; read and write drop low
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] q);
    int n;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) hung++;
    q = avs_readdata;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_address    <= ~a;
    avs_writedata  <= ~d;
    avs_byteenable <= ~be;
  endtask

  task automatic start_op(input logic [2:0] op);
    logic [31:0] q;
    access(1'b1, vcsa_pkg::OFS_ACC_EXT, 32'h0, 4'hF, q);
    access(1'b1, vcsa_pkg::OFS_CMD, {29'h0, op}, 4'hF, q);
  endtask
endmodule // vcsa_host_model

// file: tb/vcsa_top_test.sv
`timescale 1ns/1ps
module vcsa_top_test;
  typedef struct packed {
    logic [2:0]  op;
    logic [31:0] s0;
    logic [31:0] s1;
    logic [31:0] acc;
    logic [3:0]  fi;
    logic [31:0] res;
    logic [31:0] acc_o;
    logic [3:0]  fo;
  } vcsa_row_t;

  // single forms keep the upper result half of the row before
  localparam vcsa_row_t ROWS [12] = '{
    '{3'h0,32'hFFFF0000,32'h0000FFFF,32'h0,4'hF,32'h0,32'h2,4'hF},
    '{3'h1,32'hFEEDBEEF,32'hDEAF0000,32'h0,4'h0,32'hFEED0000,32'h80000000,4'h0},
    '{3'h2,32'hFFFF0000,32'h0,32'h0,4'h5,32'hFEED0000,32'h0,4'h5},
    '{3'h3,32'h1234FADE,32'h0,32'hFFFFFFFF,4'h0,32'hFEED1234,32'hFFFFFFFF,4'h0},
    '{3'h0,32'h80007FFF,32'h12341234,32'h1,4'hA,32'h80001234,32'h5,4'hA},
    '{3'h1,32'h00010002,32'h00050003,32'hC,4'h0,32'h00020005,32'h40000003,4'h0},
    '{3'h2,32'h00050001,32'h0,32'h80000000,4'h0,32'h00020005,32'h1,4'h0},
    '{3'h3,32'h00010001,32'h0,32'h1,4'h0,32'h00020001,32'h0,4'h0},
    '{3'h4,32'hFFFF7FFF,32'h0,32'h55555555,4'hA,32'h00017FFF,32'h55555555,4'h8},
    '{3'h4,32'h80000000,32'h0,32'h55555555,4'h2,32'h7FFF0000,32'h55555555,4'hD},
    '{3'h4,32'h00057FFF,32'h0,32'h55555555,4'h0,32'h00057FFF,32'h55555555,4'h0},
    '{3'h4,32'h12348000,32'h0,32'h55555555,4'h8,32'h12347FFF,32'h55555555,4'hC}
  };

  logic        clk;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  int          bad_count = 0;
  int          compares  = 0;

  vcsa_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq));

  vcsa_host_model host (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic stop_test();
    bad_count += host.hung;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.access(1'b1, a, d, 4'hF, q);
    if (host.hung != 0) stop_test();
  endtask

  task automatic rd(input logic [7:0] a, input string nm,
                    input logic [31:0] e);
    logic [31:0] q;
    host.access(1'b0, a, 32'h0, 4'hF, q);
    if (host.hung != 0) stop_test();
    chk(nm, e, q);
  endtask

  initial begin
    logic [31:0] q;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    chk_bit("reset waitrequest", 1'b1, avs_waitrequest);
    chk_bit("reset irq", 1'b0, irq);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i <= 8; i++) rd(8'(4 * i), "reset value", 32'h0);
    for (int i = 0; i < 12; i++) begin
      host.gap = i % 3;
      wr(vcsa_pkg::OFS_SRC0, ROWS[i].s0);
      wr(vcsa_pkg::OFS_SRC1, ROWS[i].s1);
      wr(vcsa_pkg::OFS_ACC_LO, ROWS[i].acc);
      wr(vcsa_pkg::OFS_FLAGS, {28'h0, ROWS[i].fi});
      host.start_op(ROWS[i].op);
      rd(vcsa_pkg::OFS_RESULT, "result", ROWS[i].res);
      rd(vcsa_pkg::OFS_ACC_LO, "history", ROWS[i].acc_o);
      rd(vcsa_pkg::OFS_FLAGS, "flags", {28'h0, ROWS[i].fo});
      rd(vcsa_pkg::OFS_ACC_EXT, "extension", 32'h0);
    end
    host.gap = 0;
    chk_bit("irq masked", 1'b0, irq);
    rd(vcsa_pkg::OFS_IRQ_ST, "irq status", 32'h3);
    rd(vcsa_pkg::OFS_IRQ_ST, "irq cleared", 32'h0);
    wr(vcsa_pkg::OFS_IRQ_MSK, 32'h4);
    host.start_op(3'h5);
    @(negedge clk);
    chk_bit("irq raised", 1'b1, irq);
    rd(vcsa_pkg::OFS_CMD, "last op", 32'h4);
    host.access(1'b0, vcsa_pkg::OFS_IRQ_ST, 32'h0, 4'hF, q);
    chk("bad command", 32'h4, q & 32'h4);
    wr(vcsa_pkg::OFS_RESULT, 32'hFFFF_FFFF);
    @(negedge clk);
    chk_bit("irq dropped", 1'b0, irq);
    rd(vcsa_pkg::OFS_RESULT, "read only", 32'h1234_7FFF);
    wr(8'h40, 32'hA5A5_A5A5);
    rd(8'h40, "unmapped", 32'h0);
    wr(vcsa_pkg::OFS_SRC0, 32'hFFFF_FFFF);
    host.access(1'b1, vcsa_pkg::OFS_SRC0, 32'h0, 4'h3, q);
    rd(vcsa_pkg::OFS_SRC0, "byte lanes", 32'hFFFF_0000);
    stop_test();
  end
endmodule // vcsa_top_test
